/* File: core/piso_shifter_params.svh */
`ifndef PISO_SHIFTER_PARAMS_SVH
`define PISO_SHIFTER_PARAMS_SVH

// number of register stages
`define PISO_STAGES 8
// index of the first stage, the one fed from the serial line
`define PISO_FIRST_STAGE 0
// reset level of every stage
`define PISO_STAGE_RESET 1'b0
// reset level of the serial output; the inverted one is its complement
`define PISO_OUT_RESET 1'b0
// edge history resets high so a level already high gives no shift
`define PISO_EDGE_HIST_RESET 1'b1

`endif

/* File: core/piso_shifter_pkg.sv */
package piso_shifter_pkg;
   `include "piso_shifter_params.svh"
   typedef logic [`PISO_STAGES-1:0] stage_vec_t;
endpackage

/* File: core/parallel_in_serial_out_shifter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "piso_shifter_params.svh"

module parallel_in_serial_out_shifter
   import piso_shifter_pkg::*;
#(
   parameter int STAGES = `PISO_STAGES
) (
   input  wire logic              clk_sys_i,
   input  wire logic              reset_i,
   input  wire logic              shift_or_load_n_i,
   input  wire logic              shift_clock_i,
   input  wire logic              clock_hold_gate_i,
   input  wire logic              serial_in_line_i,
   input  wire logic [STAGES-1:0] parallel_data_in_i,
   output var  logic              serial_out_o,
   output var  logic              serial_out_inverted_o
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic              sl_meta_q;
   logic              sl_q;
   logic              ck_meta_q;
   logic              ck_q;
   logic              gt_meta_q;
   logic              gt_q;
   logic              ser_meta_q;
   logic              ser_q;
   logic [STAGES-1:0] par_meta_q;
   logic [STAGES-1:0] par_q;

   // two flops on every pin before any logic looks at it;
   // a pin level shorter than one system clock may be lost here,
   // so every pin must stay put for at least two clocks
   // and all pins see the same two-clock delay
   always_ff @(posedge clk_sys_i) begin
      sl_meta_q  <= shift_or_load_n_i;
      sl_q       <= sl_meta_q;
      ck_meta_q  <= shift_clock_i;
      ck_q       <= ck_meta_q;
      gt_meta_q  <= clock_hold_gate_i;
      gt_q       <= gt_meta_q;
      ser_meta_q <= serial_in_line_i;
      ser_q      <= ser_meta_q;
      par_meta_q <= parallel_data_in_i;
      par_q      <= par_meta_q;
   end

   // ****************************************************************
   // edge detection of the combined clock
   // ****************************************************************
   logic ck_prev_q;
   logic gt_prev_q;
   logic eff_clk;
   logic eff_prev;
   logic shift_en;

   // previous levels of the two interchangeable clock inputs;
   // history starts high so a pin already high at release is no edge
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ck_prev_q <= `PISO_EDGE_HIST_RESET;
         gt_prev_q <= `PISO_EDGE_HIST_RESET;
      end else begin
         ck_prev_q <= ck_q;
         gt_prev_q <= gt_q;
      end
   end

   // effective clock is the or of both inputs; while either stays
   // high the or cannot rise, which is what freezes the register
   assign eff_clk  = ck_q || gt_q;
   assign eff_prev = ck_prev_q || gt_prev_q;
   assign shift_en = sl_q && eff_clk && !eff_prev;

   // ****************************************************************
   // stage register
   // ****************************************************************
   logic [STAGES-1:0] stage_q;
   logic [STAGES-1:0] stage_d;

   // next value per stage: load wins, then shift, else hold;
   // load is level sensitive so it needs no clock edge at all,
   // and a word cut short by a new load is simply replaced
   for (genvar i = 0; i < STAGES; i++) begin : g_stage
      if (i == `PISO_FIRST_STAGE) begin : g_head
         // first stage takes the serial line on a shift
         assign stage_d[i] = !sl_q    ? par_q[i] :
                             shift_en ? ser_q    : stage_q[i];
      end else begin : g_body
         // later stages take their neighbour toward the input
         assign stage_d[i] = !sl_q    ? par_q[i]     :
                             shift_en ? stage_q[i-1] : stage_q[i];
      end
   end

   // stage register, cleared by the added reset
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         stage_q <= {STAGES{`PISO_STAGE_RESET}};
      end else begin
         stage_q <= stage_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // both outputs registered from the final stage, so they move
   // together one clock after the stage register
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         serial_out_o          <= `PISO_OUT_RESET;
         serial_out_inverted_o <= ~`PISO_OUT_RESET;
      end else begin
         serial_out_o          <= stage_q[STAGES-1];
         serial_out_inverted_o <= ~stage_q[STAGES-1];
      end
   end

   // ****************************************************************
   // shift counter for coverage
   // ****************************************************************
   localparam int CNT_W = $clog2(STAGES + 1);
   logic [CNT_W-1:0] shift_cnt_q;

   // shifts since the last load, held once a full word is out;
   // only coverage reads it, the data path does not
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !sl_q) begin
         shift_cnt_q <= '0;
      end else if (shift_en && shift_cnt_q != CNT_W'(STAGES)) begin
         shift_cnt_q <= shift_cnt_q + 1'b1;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   // all checks look at synchronised pins, so they hold whatever
   // phase the pins change in relative to the system clock
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // load: parallel data taken whatever the clock inputs do,
   // and never taken while load is high
   AST_LOAD_FOLLOWS: assert property (
      !sl_q |=> stage_q == $past(par_q))
      else $error("stages did not take parallel data during load");
   AST_LOAD_IGNORES_CLOCK: assert property (
      !sl_q && (ck_q || gt_q) |=> stage_q == $past(par_q))
      else $error("clock level disturbed a parallel load");
   AST_SHIFT_OR_HOLD: assert property (
      sl_q |=> stage_q == $past(stage_q)
         || stage_q == {$past(stage_q[STAGES-2:0]), $past(ser_q)})
      else $error("stages took parallel data while load high");
   // shift: one step toward the output,
   // serial line into the first stage
   AST_SHIFT_MOVES: assert property (
      shift_en |=> stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]))
      else $error("shift did not move stages toward output");
   AST_SHIFT_SERIAL_IN: assert property (
      shift_en |=> stage_q[`PISO_FIRST_STAGE] == $past(ser_q))
      else $error("first stage missed the serial line");
   AST_HOLD_NO_PAR: assert property (
      sl_q && !shift_en |=> $stable(stage_q))
      else $error("register changed without shift while load high");
   // freeze: either input held high, or both low,
   // leaves the register alone
   AST_CLK_HIGH_FREEZE: assert property (
      sl_q && ck_prev_q |=> $stable(stage_q))
      else $error("register changed while clock held high");
   AST_GATE_HIGH_FREEZE: assert property (
      sl_q && gt_prev_q |=> $stable(stage_q))
      else $error("register changed while gate held high");
   AST_FALL_NO_SHIFT: assert property (
      sl_q && !ck_q && !gt_q |=> $stable(stage_q))
      else $error("register changed with both clock inputs low");
   // edges: a rise of either input with the other low
   // gives exactly one shift of the register
   AST_CLK_EDGE_SHIFT: assert property (
      sl_q && ck_q && !ck_prev_q && !gt_q && !gt_prev_q |=>
         stage_q == {$past(stage_q[STAGES-2:0]), $past(ser_q)})
      else $error("clock edge with gate low gave no shift");
   AST_GATE_EDGE_SHIFT: assert property (
      sl_q && gt_q && !gt_prev_q && !ck_q && !ck_prev_q |=>
         stage_q == {$past(stage_q[STAGES-2:0]), $past(ser_q)})
      else $error("gate edge with clock low gave no shift");
   // outputs: both follow the final stage one clock later
   // and stay complements of each other
   AST_COMPLEMENT: assert property (
      serial_out_inverted_o == !serial_out_o)
      else $error("inverted output not the complement");
   AST_OUT_LATENCY: assert property (
      ##1 serial_out_o == $past(stage_q[STAGES-1]))
      else $error("serial output does not track final stage");
   AST_INV_TRACK: assert property (
      ##1 serial_out_inverted_o == !$past(stage_q[STAGES-1]))
      else $error("inverted output does not track final stage");

   // main scenarios: load, both kinds of shift, a frozen edge,
   // and a whole word shifted out after one load
   COV_LOAD: cover property (!sl_q ##1 sl_q);
   COV_CLK_SHIFT: cover property (sl_q && ck_q && !ck_prev_q && shift_en);
   COV_GATE_SHIFT: cover property (sl_q && gt_q && !gt_prev_q && shift_en);
   COV_GATE_FREEZE: cover property (sl_q && gt_q && ck_q && !ck_prev_q);
   COV_EIGHT_SHIFTS: cover property (shift_cnt_q == CNT_W'(STAGES));

endmodule
`default_nettype wire

/* File: test/serial_host.sv */
`timescale 1ns/100ps
`default_nettype none
// host side: drives the shifter pins, each level held 3 cycles
module serial_host (
   input  wire logic       clk_i,
   output logic            shift_or_load_n_o,
   output logic            shift_clock_o,
   output logic            clock_hold_gate_o,
   output logic            serial_in_line_o,
   output logic [7:0]      parallel_data_in_o
);
   initial {shift_or_load_n_o, shift_clock_o, clock_hold_gate_o,
            serial_in_line_o, parallel_data_in_o} = 12'h000;
   // load, clock, gate, serial line in that order
   task automatic put(input logic [3:0] v);
      {shift_or_load_n_o, shift_clock_o, clock_hold_gate_o,
       serial_in_line_o} = v;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // parallel load, clock held at c then dropped low; gate stays low throughout
   task automatic load(input logic [7:0] d, input logic c);
      parallel_data_in_o = d;
      put({1'b0, c, 2'b00});
      put({1'b1, c, 2'b00});
      put(4'b1000);
      parallel_data_in_o = ~d; // must be ignored
   endtask
   // gate raised only while clock is high
   task automatic hold_gate();
      put(4'b1100);
      put(4'b1110);
   endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import piso_shifter_pkg::*;
   logic        clk_sys_i = 0, reset_i = 1, sl, ck, gt, si, so, son;
   stage_vec_t  pd, exp_q;
   int          n_errors = 0, n_compared = 0, cyc = 0;
   logic [31:0] rng = 32'h0000_001a;
   serial_host host (.clk_i(clk_sys_i), .shift_or_load_n_o(sl),
      .shift_clock_o(ck), .clock_hold_gate_o(gt), .serial_in_line_o(si),
      .parallel_data_in_o(pd));
   parallel_in_serial_out_shifter DUT (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .shift_or_load_n_i(sl), .shift_clock_i(ck),
      .clock_hold_gate_i(gt), .serial_in_line_i(si),
      .parallel_data_in_i(pd), .serial_out_o(so),
      .serial_out_inverted_o(son));
   always #10 clk_sys_i = ~clk_sys_i;
   // ceiling well above the roughly 430 cycles the sequence needs
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         finish_test();
      end
   end
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic stage_vec_t nxt(stage_vec_t v, logic s);
      return {v[6:0], s};
   endfunction
   task automatic check(input string what, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic outs();
      check("serial_out", exp_q[7], so);
      check("serial_out_inverted", ~exp_q[7], son);
   endtask
   // one shift by clock or by gate, random serial bit
   task automatic shift(input logic use_gate);
      logic s;
      s = ^xs();
      host.put({3'b100, s});
      host.put({1'b1, ~use_gate, use_gate, s});
      host.put({3'b100, s});
      exp_q = nxt(exp_q, s);
      outs();
   endtask
   task automatic finish_test();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ***************
   // main sequence
   // ***************
   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1 reset_i = 0;
      exp_q = 8'h00;
      outs();
      for (int i = 0; i < 5; i++) begin
         exp_q = (i == 0) ? 8'hc0 : stage_vec_t'(xs());
         host.load(exp_q, i[0]);
         outs();
         if (i == 0) begin
            host.hold_gate();
            // the clock rise inside hold_gate shifts a zero in
            exp_q = nxt(exp_q, 1'b0);
            outs();
            host.put(4'b1010);
            host.put(4'b1110);
            host.put(4'b1000);
            outs();
         end
         for (int j = 0; j < 8; j++) shift(j[0] ^ i[1]);
      end
      finish_test();
   end
endmodule
`default_nettype wire
